//--- design/lbpc_defs.vh
// constants shared by the lan bridge port control block
`ifndef LBPC_DEFS_VH
`define LBPC_DEFS_VH

// --------------------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------------------
`define LBPC_CLK_MHZ 40
`define LBPC_BLINK_US 100000
`define LBPC_PAUSE_REPEAT_US 1000
`define LBPC_STRAP_SETTLE_CYC 8

// --------------------------------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------------------------------
`define LBPC_ADDR_STATUS 8'h00
`define LBPC_ADDR_HI_THR 8'h04
`define LBPC_ADDR_LO_THR 8'h08
`define LBPC_ADDR_QUANTA 8'h0c
`define LBPC_ADDR_STRAPS 8'h10

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define LBPC_HI_THR_RST 8'hc0
`define LBPC_LO_THR_RST 8'h40
`define LBPC_QUANTA_RST 16'hffff

// --------------------------------------------------------------------------
// strap positions: bank one sections 1..8 at bits 0..7, bank two 1..6 at 0..5
// --------------------------------------------------------------------------
`define LBPC_B1_CROSSOVER 0
`define LBPC_B1_FLOW 3
`define LBPC_B1_FILTER 4
`define LBPC_B1_FAULT 5
`define LBPC_B2_SPEED 0
`define LBPC_B2_NEG 1
`define LBPC_B2_DUPLEX 2

// --------------------------------------------------------------------------
// status register fields
// --------------------------------------------------------------------------
`define LBPC_ST_LINK 0
`define LBPC_ST_FAST 1
`define LBPC_ST_FULL 2
`define LBPC_ST_NEG 3
`define LBPC_ST_FLOW 4
`define LBPC_ST_FILTER 5
`define LBPC_ST_PRESSURE 6
`define LBPC_ST_SHUTDOWN 7
`define LBPC_ST_JAM 8
`define LBPC_ST_PAUSE 9

`endif

//--- design/lbpc_sync3.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module lbpc_sync3 #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] s1_ff;
    reg [WIDTH-1:0] s2_ff;
    reg [WIDTH-1:0] s3_ff;
    integer i;

    // s1 feeds only s2; a bit moves once stages two and three agree
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_ff <= {WIDTH{1'b0}};
            s2_ff <= {WIDTH{1'b0}};
            s3_ff <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    dout[i] <= s3_ff[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- design/lbpc_top.v
// lan port strap decode, flow regulation, fault shutdown and indicators
`timescale 1ns/10ps
`default_nettype none
`include "lbpc_defs.vh"

// Operation
// - crossover strap on disables automatic crossover
// - flow strap enables backpressure and pause together
// - pause frames only with autonegotiation enabled; code still sends a zero-time resume pause if it goes off in PS_HOLD
// - filter strap on disables lan filtering
// - propagation enabled: e1 failure shuts lan
// - speed strap on gives 10, off 100
// - negotiation strap on disables autonegotiation
// - duplex strap on half, off full
// - negotiation decides speed and duplex, straps ignored
// - flow and filter straps latched at reset
// - half duplex pressure forces collisions
// - full duplex pressure sends pause frames
// - link indicator steady while link up
// - activity indicator blinks on traffic
// - speed indicator lit at 100 only
module lbpc_top #(
    parameter LEVEL_W = 8,
    parameter BLINK_CYC = `LBPC_BLINK_US * `LBPC_CLK_MHZ,
    parameter PAUSE_REPEAT_CYC = `LBPC_PAUSE_REPEAT_US * `LBPC_CLK_MHZ
) (
    input wire CLK_SYS,
    input wire SYS_RST,
    input wire [7:0] SWITCH_BANK_ONE,
    input wire [5:0] SWITCH_BANK_TWO,
    input wire PHY_LINK_UP,
    input wire PHY_NEG_FAST,
    input wire PHY_NEG_FULL,
    input wire PHY_TX_ACT,
    input wire PHY_RX_ACT,
    input wire PHY_CRS,
    input wire E1_FAIL,
    input wire [LEVEL_W-1:0] BUF_LEVEL,
    input wire PAUSE_ACK,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    output reg PHY_AUTO_XOVER,
    output reg PHY_NEG_EN,
    output reg PHY_FORCE_FAST,
    output reg PHY_FORCE_FULL,
    output reg PHY_SHUTDOWN,
    output reg LAN_FILTER_EN,
    output reg JAM,
    output reg PAUSE_REQ,
    output reg [15:0] PAUSE_TIME,
    output reg LED_LINK,
    output reg LED_ACT,
    output reg FAST_SPEED_INDICATOR
);

    // ----------------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------------
    localparam PIN_W = 21;

    wire [PIN_W-1:0] pin_raw;
    wire [PIN_W-1:0] pin_sync;

    assign pin_raw = {SWITCH_BANK_ONE, SWITCH_BANK_TWO, PHY_LINK_UP, PHY_NEG_FAST,
                      PHY_NEG_FULL, PHY_TX_ACT, PHY_RX_ACT, PHY_CRS, E1_FAIL};

    lbpc_sync3 #(
        .WIDTH(PIN_W)
    ) u_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .din(pin_raw),
        .dout(pin_sync)
    );

    wire [7:0] switch_bank_one;
    wire [5:0] switch_bank_two;
    wire link_up;
    wire neg_fast;
    wire neg_full;
    wire tx_act;
    wire rx_act;
    wire crs;
    wire e1_fail;

    assign switch_bank_one = pin_sync[20:13];
    assign switch_bank_two = pin_sync[12:7];
    assign link_up = pin_sync[6];
    assign neg_fast = pin_sync[5];
    assign neg_full = pin_sync[4];
    assign tx_act = pin_sync[3];
    assign rx_act = pin_sync[2];
    assign crs = pin_sync[1];
    assign e1_fail = pin_sync[0];

    wire crossover_strap;
    wire fault_propagation_strap;
    wire speed_strap;
    wire negotiation_strap;
    wire duplex_strap;

    assign crossover_strap = switch_bank_one[`LBPC_B1_CROSSOVER];
    assign fault_propagation_strap = switch_bank_one[`LBPC_B1_FAULT];
    assign speed_strap = switch_bank_two[`LBPC_B2_SPEED];
    assign negotiation_strap = switch_bank_two[`LBPC_B2_NEG];
    assign duplex_strap = switch_bank_two[`LBPC_B2_DUPLEX];

    // ----------------------------------------------------------------------
    // reset-time strap capture
    // ----------------------------------------------------------------------
    // the synchroniser outputs read zero during reset, so capture waits until
    // they have had time to settle; after that the straps are frozen
    reg [3:0] settle_ff;
    reg flow_regulation_strap_ff;
    reg lan_filter_strap_ff;

    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            settle_ff <= 4'h0;
            flow_regulation_strap_ff <= 1'b0;
            lan_filter_strap_ff <= 1'b0;
        end else if (settle_ff < `LBPC_STRAP_SETTLE_CYC) begin
            settle_ff <= settle_ff + 4'h1;
            flow_regulation_strap_ff <= switch_bank_one[`LBPC_B1_FLOW];
            lan_filter_strap_ff <= switch_bank_one[`LBPC_B1_FILTER];
        end
    end

    // ----------------------------------------------------------------------
    // mode resolution
    // ----------------------------------------------------------------------
    wire neg_en;
    wire mode_fast;
    wire mode_full;
    wire flow_en;
    wire shutdown;

    assign neg_en = ~negotiation_strap;
    assign mode_fast = neg_en ? neg_fast : ~speed_strap;
    assign mode_full = neg_en ? neg_full : ~duplex_strap;
    assign flow_en = flow_regulation_strap_ff;
    assign shutdown = ~fault_propagation_strap & e1_fail;

    wire link_ok;
    assign link_ok = link_up & ~shutdown;

    // ----------------------------------------------------------------------
    // buffer pressure with hysteresis
    // ----------------------------------------------------------------------
    reg [LEVEL_W-1:0] hi_thr_ff;
    reg [LEVEL_W-1:0] lo_thr_ff;
    reg [15:0] quanta_ff;
    reg pressure_ff;

    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            pressure_ff <= 1'b0;
        end else if (BUF_LEVEL >= hi_thr_ff) begin
            pressure_ff <= 1'b1;
        end else if (BUF_LEVEL < lo_thr_ff) begin
            pressure_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // half duplex backpressure
    // ----------------------------------------------------------------------
    // jamming only while the partner transmits turns its frame into a
    // collision; jamming an idle wire would just add load
    wire jam_cond;
    assign jam_cond = flow_en & ~mode_full & pressure_ff & crs & link_ok;

    // ----------------------------------------------------------------------
    // full duplex pause sequencer
    // ----------------------------------------------------------------------
    localparam PS_IDLE = 2'b00;
    localparam PS_SEND = 2'b01;
    localparam PS_HOLD = 2'b10;
    localparam PS_RESUME = 2'b11;

    wire pause_allowed;
    assign pause_allowed = flow_en & neg_en & mode_full & link_ok;

    reg [1:0] ps_state_ff;
    reg [1:0] nxt_ps_state;
    reg [31:0] repeat_cnt_ff;
    reg [31:0] nxt_repeat_cnt;
    reg nxt_pause_req;
    reg [15:0] nxt_pause_time;

    always @* begin
        nxt_ps_state = ps_state_ff;
        nxt_repeat_cnt = repeat_cnt_ff;
        nxt_pause_req = PAUSE_REQ;
        nxt_pause_time = PAUSE_TIME;
        case (ps_state_ff)
            PS_IDLE: begin
                if (pause_allowed && pressure_ff) begin
                    nxt_ps_state = PS_SEND;
                    nxt_pause_req = 1'b1;
                    nxt_pause_time = quanta_ff;
                end
            end
            PS_SEND: begin
                if (PAUSE_ACK) begin
                    nxt_pause_req = 1'b0;
                    nxt_repeat_cnt = 32'h0;
                    nxt_ps_state = (nxt_pause_time == 16'h0000) ? PS_IDLE : PS_HOLD;
                end
            end
            PS_HOLD: begin
                // the partner sits out each interval; refresh before it lapses
                if (!pause_allowed || !pressure_ff) begin
                    nxt_ps_state = PS_RESUME;
                end else if (repeat_cnt_ff >= PAUSE_REPEAT_CYC - 1) begin
                    nxt_ps_state = PS_SEND;
                    nxt_pause_req = 1'b1;
                    nxt_pause_time = quanta_ff;
                end else begin
                    nxt_repeat_cnt = repeat_cnt_ff + 32'h1;
                end
            end
            PS_RESUME: begin
                // a zero-time pause lets the partner restart at once
                nxt_ps_state = PS_SEND;
                nxt_pause_req = 1'b1;
                nxt_pause_time = 16'h0000;
            end
            default: begin
                nxt_ps_state = PS_IDLE;
                nxt_pause_req = 1'b0;
            end
        endcase
    end

    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ps_state_ff <= PS_IDLE;
            repeat_cnt_ff <= 32'h0;
            PAUSE_REQ <= 1'b0;
            PAUSE_TIME <= 16'h0000;
        end else begin
            ps_state_ff <= nxt_ps_state;
            repeat_cnt_ff <= nxt_repeat_cnt;
            PAUSE_REQ <= nxt_pause_req;
            PAUSE_TIME <= nxt_pause_time;
        end
    end

    // ----------------------------------------------------------------------
    // activity blink
    // ----------------------------------------------------------------------
    // one blink per period at most: bursts of traffic do not turn into a
    // steady light, they keep the led flashing
    reg [31:0] blink_cnt_ff;
    reg act_seen_ff;
    reg act_blink_ff;

    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            blink_cnt_ff <= 32'h0;
            act_seen_ff <= 1'b0;
            act_blink_ff <= 1'b0;
        end else if (blink_cnt_ff >= BLINK_CYC - 1) begin
            blink_cnt_ff <= 32'h0;
            act_blink_ff <= act_seen_ff | tx_act | rx_act;
            act_seen_ff <= 1'b0;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 32'h1;
            if (tx_act || rx_act) begin
                act_seen_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------------
    wire [31:0] status_word;
    assign status_word = {22'h000000, PAUSE_REQ, JAM, shutdown, pressure_ff,
                          lan_filter_strap_ff, flow_en, neg_en, mode_full, mode_fast, link_ok};

    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            hi_thr_ff <= `LBPC_HI_THR_RST;
            lo_thr_ff <= `LBPC_LO_THR_RST;
            quanta_ff <= `LBPC_QUANTA_RST;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `LBPC_ADDR_HI_THR: hi_thr_ff <= REG_WDATA[LEVEL_W-1:0];
                `LBPC_ADDR_LO_THR: lo_thr_ff <= REG_WDATA[LEVEL_W-1:0];
                `LBPC_ADDR_QUANTA: quanta_ff <= REG_WDATA[15:0];
                default: begin
                end
            endcase
        end
    end

    reg [31:0] nxt_rdata;

    always @* begin
        nxt_rdata = 32'h0;
        case (REG_ADDR)
            `LBPC_ADDR_STATUS: nxt_rdata = status_word;
            `LBPC_ADDR_HI_THR: nxt_rdata[LEVEL_W-1:0] = hi_thr_ff;
            `LBPC_ADDR_LO_THR: nxt_rdata[LEVEL_W-1:0] = lo_thr_ff;
            `LBPC_ADDR_QUANTA: nxt_rdata[15:0] = quanta_ff;
            `LBPC_ADDR_STRAPS: nxt_rdata[13:0] = {switch_bank_two, switch_bank_one};
            default: nxt_rdata = 32'h0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h0;
        end else if (REG_RD) begin
            REG_RDATA <= nxt_rdata;
        end else begin
            REG_RDATA <= 32'h0;
        end
    end

    // ----------------------------------------------------------------------
    // phy controls and indicators
    // ----------------------------------------------------------------------
    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            PHY_AUTO_XOVER <= 1'b0;
            PHY_NEG_EN <= 1'b0;
            PHY_FORCE_FAST <= 1'b0;
            PHY_FORCE_FULL <= 1'b0;
            PHY_SHUTDOWN <= 1'b1;
            LAN_FILTER_EN <= 1'b0;
            JAM <= 1'b0;
            LED_LINK <= 1'b0;
            LED_ACT <= 1'b0;
            FAST_SPEED_INDICATOR <= 1'b0;
        end else begin
            PHY_AUTO_XOVER <= ~crossover_strap;
            PHY_NEG_EN <= neg_en;
            PHY_FORCE_FAST <= ~speed_strap;
            PHY_FORCE_FULL <= ~duplex_strap;
            PHY_SHUTDOWN <= shutdown;
            LAN_FILTER_EN <= ~lan_filter_strap_ff;
            JAM <= jam_cond;
            LED_LINK <= link_ok;
            LED_ACT <= act_blink_ff & link_ok & (blink_cnt_ff < (BLINK_CYC >> 1));
            FAST_SPEED_INDICATOR <= link_ok & mode_fast;
        end
    end

endmodule

`default_nettype wire

//--- verif/lbpc_monitor.sv
// concurrent checks on the lan port control outputs
`timescale 1ns/10ps
`default_nettype none
module lbpc_monitor (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic [7:0] SWITCH_BANK_ONE,
    input wire logic [5:0] SWITCH_BANK_TWO,
    input wire logic PHY_LINK_UP,
    input wire logic PHY_NEG_FAST,
    input wire logic E1_FAIL,
    input wire logic PAUSE_ACK,
    input wire logic PAUSE_REQ,
    input wire logic [15:0] PAUSE_TIME,
    input wire logic JAM,
    input wire logic PHY_AUTO_XOVER,
    input wire logic PHY_NEG_EN,
    input wire logic PHY_FORCE_FULL,
    input wire logic PHY_SHUTDOWN,
    input wire logic LED_LINK,
    input wire logic FAST_SPEED_INDICATOR
);
    wire logic shut_exp = !SWITCH_BANK_ONE[5] && E1_FAIL;
    wire logic fast_exp = SWITCH_BANK_TWO[1] ? !SWITCH_BANK_TWO[0] : PHY_NEG_FAST;
    default clocking mon_cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);
    // ------------------
    // sequences
    // ------------------
    // long enough to cross the synchroniser and agree filter
    sequence pins_quiet;
        $stable({SWITCH_BANK_ONE, SWITCH_BANK_TWO, PHY_LINK_UP, PHY_NEG_FAST, E1_FAIL})[*8];
    endsequence
    sequence pause_waiting;
        PAUSE_REQ && !PAUSE_ACK;
    endsequence
    sequence pause_taken;
        PAUSE_REQ && PAUSE_ACK;
    endsequence
    // ------------------
    // properties
    // ------------------
    chk_xover_strap: assert property (pins_quiet |-> PHY_AUTO_XOVER == !SWITCH_BANK_ONE[0])
        else $error("crossover enable wrong");
    chk_neg_strap: assert property (pins_quiet |-> PHY_NEG_EN == !SWITCH_BANK_TWO[1])
        else $error("negotiation enable wrong");
    chk_forced_duplex: assert property (pins_quiet ##0 SWITCH_BANK_TWO[1] |->
        PHY_FORCE_FULL == !SWITCH_BANK_TWO[2]) else $error("forced duplex wrong");
    chk_fault_shut: assert property (pins_quiet |-> PHY_SHUTDOWN == shut_exp)
        else $error("shutdown wrong");
    chk_link_lamp: assert property (pins_quiet |-> LED_LINK == (PHY_LINK_UP && !shut_exp))
        else $error("link lamp wrong");
    chk_speed_lamp: assert property (pins_quiet |->
        FAST_SPEED_INDICATOR == (PHY_LINK_UP && !shut_exp && fast_exp))
        else $error("speed lamp wrong");
    chk_pause_hold: assert property (pause_waiting |=> PAUSE_REQ && $stable(PAUSE_TIME))
        else $error("pause request dropped early");
    chk_pause_drop: assert property (pause_taken |=> !PAUSE_REQ)
        else $error("pause request held after ack");
    chk_pause_neg: assert property ($rose(PAUSE_REQ) |-> PHY_NEG_EN)
        else $error("pause without negotiation");
    chk_jam_mode: assert property ($rose(JAM) |-> !PAUSE_REQ && !PHY_SHUTDOWN)
        else $error("jam in wrong mode");
endmodule
bind lbpc_top lbpc_monitor lbpc_monitor_i (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SWITCH_BANK_ONE(SWITCH_BANK_ONE),
    .SWITCH_BANK_TWO(SWITCH_BANK_TWO), .PHY_LINK_UP(PHY_LINK_UP), .PHY_NEG_FAST(PHY_NEG_FAST),
    .E1_FAIL(E1_FAIL), .PAUSE_ACK(PAUSE_ACK), .PAUSE_REQ(PAUSE_REQ), .PAUSE_TIME(PAUSE_TIME),
    .JAM(JAM), .PHY_AUTO_XOVER(PHY_AUTO_XOVER), .PHY_NEG_EN(PHY_NEG_EN),
    .PHY_FORCE_FULL(PHY_FORCE_FULL), .PHY_SHUTDOWN(PHY_SHUTDOWN), .LED_LINK(LED_LINK),
    .FAST_SPEED_INDICATOR(FAST_SPEED_INDICATOR));
`default_nettype wire

//--- verif/lbpc_partner.sv
// ethernet link partner model: link state, traffic and pause handling
`timescale 1ns/10ps
`default_nettype none
module lbpc_partner (
    input wire logic clk,
    input wire logic link_en,
    input wire logic [1:0] neg_mode,
    input wire logic traffic,
    input wire logic [3:0] ack_lag,
    input wire logic pause_req,
    input wire logic [15:0] pause_time,
    output logic link_up,
    output logic neg_fast,
    output logic neg_full,
    output logic rx_act,
    output logic crs,
    output logic pause_ack
);
    int lag_cnt = 0;
    int halt_cnt = 0;
    initial begin
        {link_up, neg_fast, neg_full, rx_act, crs, pause_ack} = 6'h00;
    end
    // slow acks stretch the request so its hold is exercised
    always @(posedge clk) begin
        link_up <= link_en;
        {neg_fast, neg_full} <= neg_mode;
        pause_ack <= 1'b0;
        if (pause_req && !pause_ack) begin
            lag_cnt <= lag_cnt + 1;
            if (lag_cnt >= int'(ack_lag)) begin
                pause_ack <= 1'b1;
                lag_cnt <= 0;
                halt_cnt <= int'(pause_time);
            end
        end else if (halt_cnt > 0) begin
            halt_cnt <= halt_cnt - 1;
        end
        rx_act <= traffic && link_en && halt_cnt == 0;
        crs <= traffic && link_en;
    end
endmodule
`default_nettype wire

//--- verif/lbpc_top_tb.sv
// self-checking bench for the lan port control block
`timescale 1ns/10ps
`default_nettype none
module lbpc_top_tb;
    localparam int BLINK = 20;
    localparam int REPEAT = 16;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] bank_one = 8'h00;
    logic [5:0] bank_two = 6'h00;
    logic tx_act = 1'b0;
    logic e1_fail = 1'b0;
    logic [7:0] buf_level = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic link_en = 1'b1;
    logic [1:0] neg_mode = 2'h3;
    logic traffic = 1'b0;
    logic [3:0] ack_lag = 4'h2;
    wire logic link_up, neg_fast, neg_full, rx_act, crs, pause_ack, auto_xover, neg_en;
    wire logic force_fast, force_full, shutdown, filter_en, jam, pause_req, led_link, led_act;
    wire logic fast_led;
    wire logic [15:0] pause_time;
    wire logic [31:0] reg_rdata;
    int num_errors = 0;
    int n_tests = 0;
    int seed = 4;
    logic [7:0] b1;
    logic [5:0] b2;
    logic [3:0] rnd;
    logic shut;
    logic fast;

    always #12.5 clk_sys = ~clk_sys;

    lbpc_top #(.LEVEL_W(8), .BLINK_CYC(BLINK), .PAUSE_REPEAT_CYC(REPEAT)) lbpc_top_i (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SWITCH_BANK_ONE(bank_one),
        .SWITCH_BANK_TWO(bank_two), .PHY_LINK_UP(link_up), .PHY_NEG_FAST(neg_fast),
        .PHY_NEG_FULL(neg_full), .PHY_TX_ACT(tx_act), .PHY_RX_ACT(rx_act), .PHY_CRS(crs),
        .E1_FAIL(e1_fail), .BUF_LEVEL(buf_level), .PAUSE_ACK(pause_ack), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .PHY_AUTO_XOVER(auto_xover), .PHY_NEG_EN(neg_en), .PHY_FORCE_FAST(force_fast),
        .PHY_FORCE_FULL(force_full), .PHY_SHUTDOWN(shutdown), .LAN_FILTER_EN(filter_en),
        .JAM(jam), .PAUSE_REQ(pause_req), .PAUSE_TIME(pause_time), .LED_LINK(led_link),
        .LED_ACT(led_act), .FAST_SPEED_INDICATOR(fast_led));

    lbpc_partner lbpc_partner_i (
        .clk(clk_sys), .link_en(link_en), .neg_mode(neg_mode), .traffic(traffic),
        .ack_lag(ack_lag), .pause_req(pause_req), .pause_time(pause_time), .link_up(link_up),
        .neg_fast(neg_fast), .neg_full(neg_full), .rx_act(rx_act), .crs(crs),
        .pause_ack(pause_ack));

    // ------------------
    // helpers
    // ------------------
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic cmp_pin(input logic exp, input logic got);
        cmp_word({31'h0, exp}, {31'h0, got});
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return pause_req;
            1: return jam;
            default: return led_act;
        endcase
    endfunction
    task automatic wait_for(input int sel, input int lim, input logic want);
        int k;
        for (k = 0; k < lim && pick(sel) !== want; k++) begin
            @(posedge clk_sys);
            #1;
        end
        if (k == lim) begin
            num_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, want, pick(sel));
            print_verdict();
        end
    endtask
    task automatic hold_low(input int sel, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1 cmp_pin(1'b0, pick(sel));
        end
    endtask
    // a gap cycle after each strobe keeps one assignment per time step
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 cmp_word(exp, reg_rdata);
        @(posedge clk_sys);
        #1 cmp_word(32'h0, reg_rdata);
    endtask
    task automatic do_reset(input logic [7:0] s1, input logic [5:0] s2);
        sys_rst <= 1'b1;
        bank_one <= s1;
        bank_two <= s2;
        buf_level <= 8'h00;
        traffic <= 1'b0;
        e1_fail <= 1'b0;
        link_en <= 1'b1;
        neg_mode <= 2'h3;
        cycles(20);
        sys_rst <= 1'b0;
        cycles(12);
    endtask

    // ------------------
    // main sequence
    // ------------------
    initial begin
        do_reset(8'h00, 6'h00);
        reg_read(8'h04, 32'h000000c0);
        reg_read(8'h08, 32'h00000040);
        reg_read(8'h0c, 32'h0000ffff);
        reg_read(8'h14, 32'h00000000);
        reg_write(8'h0c, 32'hdead1234);
        reg_read(8'h0c, 32'h00001234);
        reg_write(8'h10, 32'hffffffff);
        reg_read(8'h10, 32'h00000000);
        // filter strap latched clear at reset, random changes must not reach it
        for (int i = 0; i < 10; i++) begin
            b1 = 8'($random(seed));
            b2 = 6'($random(seed));
            rnd = 4'($random(seed));
            bank_one <= b1;
            bank_two <= b2;
            e1_fail <= rnd[0];
            link_en <= rnd[1];
            neg_mode <= rnd[3:2];
            cycles(12);
            #1;
            shut = !b1[5] && rnd[0];
            fast = b2[1] ? !b2[0] : rnd[3];
            cmp_pin(!b1[0], auto_xover);
            cmp_pin(!b2[1], neg_en);
            cmp_pin(shut, shutdown);
            cmp_pin(rnd[1] && !shut, led_link);
            cmp_pin(rnd[1] && !shut && fast, fast_led);
            if (b2[1]) cmp_pin(!b2[2], force_full);
            if (b2[1]) cmp_pin(!b2[0], force_fast);
            cmp_pin(1'b1, filter_en);
            reg_read(8'h10, {18'h0, b2, b1});
        end
        do_reset(8'h10, 6'h00);
        cmp_pin(1'b0, filter_en);
        reg_read(8'h00, 32'h0000002f);
        do_reset(8'h08, 6'h00);
        reg_write(8'h0c, 32'h00000010);
        buf_level <= 8'hbf;
        hold_low(0, 10);
        buf_level <= 8'hc0;
        wait_for(0, 8, 1'b1);
        cmp_word(32'h10, {16'h0, pause_time});
        wait_for(0, 12, 1'b0);
        ack_lag <= 4'h7;
        buf_level <= 8'h80;
        wait_for(0, REPEAT + 8, 1'b1);
        cmp_word(32'h10, {16'h0, pause_time});
        wait_for(0, 16, 1'b0);
        buf_level <= 8'h3f;
        wait_for(0, REPEAT + 8, 1'b1);
        cmp_word(32'h0, {16'h0, pause_time});
        do_reset(8'h08, 6'h02);
        buf_level <= 8'hc0;
        hold_low(0, 30);
        do_reset(8'h00, 6'h00);
        buf_level <= 8'hc0;
        hold_low(0, 20);
        do_reset(8'h08, 6'h06);
        traffic <= 1'b1;
        buf_level <= 8'hc0;
        wait_for(1, 12, 1'b1);
        buf_level <= 8'h3f;
        wait_for(1, 12, 1'b0);
        do_reset(8'h00, 6'h06);
        traffic <= 1'b1;
        buf_level <= 8'hc0;
        hold_low(1, 20);
        do_reset(8'h00, 6'h00);
        hold_low(2, 2 * BLINK);
        // a four-cycle pulse gets past the agreement filter and lights the activity led
        tx_act <= 1'b1;
        cycles(4);
        tx_act <= 1'b0;
        wait_for(2, 2 * BLINK + 8, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
